// ### inc/cmgt_pkg.sv
package cmgt_pkg;

  // Command byte that opens the parameter sequence
  localparam logic [7:0] CMD_CODE        = 8'hB4;
  localparam int         PARAM_COUNT     = 20;
  localparam logic [4:0] PARAM_LAST      = 5'h13;

  // Parameter indices, counted from zero
  localparam logic [4:0] P_INV           = 5'h00;
  localparam logic [4:0] P_SPLD_HI       = 5'h01;
  localparam logic [4:0] P_SPLD_LO       = 5'h02;
  localparam logic [4:0] P_SP_RISE       = 5'h03;
  localparam logic [4:0] P_SP_END        = 5'h04;
  localparam logic [4:0] P_CKLD          = 5'h05;
  localparam logic [4:0] P_CK_RISE       = 5'h06;
  localparam logic [4:0] P_CK_END        = 5'h07;
  localparam logic [4:0] P_SP_HIGH       = 5'h08;
  localparam logic [4:0] P_CK_WP         = 5'h09;
  localparam logic [4:0] P_PHASE0        = 5'h0A;
  localparam logic [4:0] P_EQ            = 5'h13;

  // Field positions
  localparam int INV_NORM_LSB            = 0;
  localparam int INV_IDLE_LSB            = 3;
  localparam int HI_NIB_LSB              = 4;
  localparam int LO_NIB_LSB              = 0;

  // Inversion encodings
  localparam logic [2:0] INV_COLUMN      = 3'h0;
  localparam logic [2:0] INV_DOT1        = 3'h1;
  localparam logic [2:0] INV_DOT2        = 3'h2;
  localparam logic [2:0] INV_DOT4        = 3'h3;

  // Timing
  localparam int          OSC_PER_STEP   = 4;
  localparam logic [11:0] LINE_BASE_CYC  = 12'h0258;
  localparam int          PHASES         = 9;

  // Reset values of the stored fields
  localparam logic [7:0] RST_BYTE        = 8'h00;
  localparam logic [7:0] RST_SP_END      = 8'h04;
  localparam logic [7:0] RST_CK_END      = 8'h04;

  typedef struct packed {
    logic [2:0]  inv_norm;
    logic [2:0]  inv_idle;
    logic [11:0] sp_line_delay;
    logic [7:0]  sp_rise;
    logic [7:0]  sp_end;
    logic [3:0]  sp_high;
    logic [7:0]  ck_line_delay;
    logic [7:0]  ck_rise;
    logic [7:0]  ck_end;
    logic [3:0]  ck_high;
    logic [3:0]  ck_period;
    logic [71:0] phase;
    logic [3:0]  eq_time;
  } cmgt_cfg_s;

  typedef enum logic [1:0] {
    CMGT_IDLE,
    CMGT_PARAM
  } cmgt_rx_e;

endpackage

// ### src/cmgt_step_timer.sv
`timescale 1ns/1ns
// Fires once per line when the in-line cycle reaches value*4
module cmgt_step_timer
  import cmgt_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic [11:0] line_pos_in,
  input  wire logic [7:0]  step_in,
  output logic             hit_out
);

  logic [11:0] target;
  assign target = {2'b00, step_in, 2'b00};

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      hit_out <= 1'b0;
    end else begin
      hit_out <= (line_pos_in == target);
    end
  end

endmodule

// ### src/cmgt_timing_gen.sv
`timescale 1ns/1ns
// Contract
// - Command byte B4 starts intake of up to twenty ordered parameter bytes.
// - Parameter one holds normal and partial-idle 3-bit inversion selectors; codes 4-7 forbidden.
// - 12-bit start-pulse line delay from parameters two and three, in lines.
// - Start-pulse rise point within line, four oscillator cycles per step.
// - Start-pulse end point within line, four oscillator cycles per step.
// - Start pulse stays high value plus one lines.
// - Shift-pulse line delay postpones first shift pulse by value lines.
// - Shift-pulse end point within line, four oscillator cycles per step.
// - Each shift pulse stays high value plus one lines.
// - Shift pulse repeats every value plus one lines.
// - Nine phase times, four oscillator cycles per step, 0 to 1020.
// - Equalizing period four cycles per step, 0 to 60.
// - Line lasts 600 plus four times line-length setting cycles.
module cmgt_timing_gen
  import cmgt_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        write_strobe_in,
  input  wire logic        data_command_select_in,
  input  wire logic [7:0]  data_in,
  input  wire logic [7:0]  line_length_setting_in,
  input  wire logic [10:0] frame_lines_in,
  input  wire logic        partial_idle_in,
  output logic             frame_start_out,
  output logic             line_start_out,
  output logic [1:0]       inversion_select_out,
  output logic             inversion_illegal_out,
  output logic             gate_start_pulse_out,
  output logic             gate_shift_pulse_out,
  output logic [3:0]       phase_index_out,
  output logic             timing_generator_output_out,
  output logic             equalize_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Parameter intake

  cmgt_rx_e  rx_q;
  logic [4:0] idx_q;
  cmgt_cfg_s shadow_q;
  cmgt_cfg_s active_q;
  logic       take_cmd;
  logic       take_par;

  assign take_cmd = write_strobe_in && !data_command_select_in;
  assign take_par = write_strobe_in && data_command_select_in && (rx_q == CMGT_PARAM);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rx_q  <= CMGT_IDLE;
      idx_q <= 5'h00;
    end else if (take_cmd) begin
      rx_q  <= (data_in == CMD_CODE) ? CMGT_PARAM : CMGT_IDLE;
      idx_q <= 5'h00;
    end else if (take_par) begin
      idx_q <= idx_q + 5'h01;
      if (idx_q == PARAM_LAST) begin
        rx_q <= CMGT_IDLE;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      shadow_q         <= '0;
      shadow_q.sp_end  <= RST_SP_END;
      shadow_q.ck_end  <= RST_CK_END;
    end else if (take_par) begin
      unique case (idx_q)
        P_INV: begin
          shadow_q.inv_norm <= data_in[INV_NORM_LSB +: 3];
          shadow_q.inv_idle <= data_in[INV_IDLE_LSB +: 3];
        end
        P_SPLD_HI: shadow_q.sp_line_delay[11:8] <= data_in[LO_NIB_LSB +: 4];
        P_SPLD_LO: shadow_q.sp_line_delay[7:0]  <= data_in;
        P_SP_RISE: shadow_q.sp_rise <= data_in;
        P_SP_END:  shadow_q.sp_end  <= data_in;
        P_CKLD:    shadow_q.ck_line_delay <= data_in;
        P_CK_RISE: shadow_q.ck_rise <= data_in;
        P_CK_END:  shadow_q.ck_end  <= data_in;
        P_SP_HIGH: shadow_q.sp_high <= data_in[HI_NIB_LSB +: 4];
        P_CK_WP: begin
          shadow_q.ck_high   <= data_in[HI_NIB_LSB +: 4];
          shadow_q.ck_period <= data_in[LO_NIB_LSB +: 4];
        end
        P_EQ:      shadow_q.eq_time <= data_in[LO_NIB_LSB +: 4];
        default: begin
          if (idx_q >= P_PHASE0 && idx_q < P_EQ) begin
            shadow_q.phase[8*(idx_q - P_PHASE0) +: 8] <= data_in;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Line and frame counters

  logic [11:0] line_pos_q;
  logic [11:0] line_end;
  logic [10:0] line_no_q;
  logic        line_wrap;
  logic        frame_wrap;

  assign line_end   = LINE_BASE_CYC + {2'b00, line_length_setting_in, 2'b00} - 12'h001;
  assign line_wrap  = (line_pos_q == line_end);
  assign frame_wrap = line_wrap && (line_no_q >= frame_lines_in - 11'h001);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      line_pos_q <= 12'h000;
    end else begin
      line_pos_q <= line_wrap ? 12'h000 : line_pos_q + 12'h001;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      line_no_q <= 11'h000;
    end else if (frame_wrap) begin
      line_no_q <= 11'h000;
    end else if (line_wrap) begin
      line_no_q <= line_no_q + 11'h001;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      active_q        <= '0;
      active_q.sp_end <= RST_SP_END;
      active_q.ck_end <= RST_CK_END;
    end else if (frame_wrap) begin
      active_q <= shadow_q;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      frame_start_out <= 1'b0;
      line_start_out  <= 1'b0;
    end else begin
      frame_start_out <= frame_wrap;
      line_start_out  <= line_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Inversion select

  logic [2:0] inv_sel;
  assign inv_sel = partial_idle_in ? active_q.inv_idle : active_q.inv_norm;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      inversion_select_out  <= INV_COLUMN[1:0];
      inversion_illegal_out <= 1'b0;
    end else begin
      inversion_select_out  <= inv_sel[1:0];
      inversion_illegal_out <= inv_sel[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // In-line points

  logic sp_rise_hit;
  logic sp_end_hit;
  logic ck_rise_hit;
  logic ck_end_hit;

  cmgt_step_timer u_sp_rise (
    .sys_clk_in  (sys_clk_in),
    .rst_in      (rst_in),
    .line_pos_in (line_pos_q),
    .step_in     (active_q.sp_rise),
    .hit_out     (sp_rise_hit)
  );
  cmgt_step_timer u_sp_end (
    .sys_clk_in  (sys_clk_in),
    .rst_in      (rst_in),
    .line_pos_in (line_pos_q),
    .step_in     (active_q.sp_end),
    .hit_out     (sp_end_hit)
  );
  cmgt_step_timer u_ck_rise (
    .sys_clk_in  (sys_clk_in),
    .rst_in      (rst_in),
    .line_pos_in (line_pos_q),
    .step_in     (active_q.ck_rise),
    .hit_out     (ck_rise_hit)
  );
  cmgt_step_timer u_ck_end (
    .sys_clk_in  (sys_clk_in),
    .rst_in      (rst_in),
    .line_pos_in (line_pos_q),
    .step_in     (active_q.ck_end),
    .hit_out     (ck_end_hit)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Gate start pulse: rises on line (delay), rise point; ends on line (delay+high), end point

  logic [11:0] sp_first;
  logic [11:0] sp_last;
  assign sp_first = active_q.sp_line_delay;
  assign sp_last  = active_q.sp_line_delay + {8'h00, active_q.sp_high};

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      gate_start_pulse_out <= 1'b0;
    end else if (sp_rise_hit && ({1'b0, line_no_q} == sp_first)) begin
      gate_start_pulse_out <= 1'b1;
    end else if (sp_end_hit && ({1'b0, line_no_q} == sp_last)) begin
      gate_start_pulse_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Gate shift pulse: after delay lines, repeats every period+1 lines, high high+1 lines

  logic [3:0] ck_phase_q;
  logic [3:0] ck_hi_left_q;
  logic       ck_started;
  logic       ck_rise_line;

  assign ck_started   = ({1'b0, line_no_q} >= {4'h0, active_q.ck_line_delay});
  assign ck_rise_line = ck_started && (ck_phase_q == 4'h0);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || frame_wrap) begin
      ck_phase_q <= 4'h0;
    end else if (line_wrap && ({1'b0, line_no_q} >= {4'h0, active_q.ck_line_delay})) begin
      ck_phase_q <= (ck_phase_q == active_q.ck_period) ? 4'h0 : ck_phase_q + 4'h1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      gate_shift_pulse_out <= 1'b0;
      ck_hi_left_q         <= 4'h0;
    end else if (ck_rise_hit && ck_rise_line) begin
      gate_shift_pulse_out <= 1'b1;
      ck_hi_left_q         <= active_q.ck_high;
    end else if (line_wrap && gate_shift_pulse_out && ck_hi_left_q != 4'h0) begin
      ck_hi_left_q <= ck_hi_left_q - 4'h1;
    end else if (ck_end_hit && ck_hi_left_q == 4'h0) begin
      gate_shift_pulse_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Phase sequencer t1..t9 then equalize, restarted each line

  logic [9:0]  ph_cnt_q;
  logic [3:0]  ph_q;
  logic [7:0]  ph_len;
  logic [9:0]  ph_lim;
  logic [9:0]  eq_lim;
  logic [9:0]  ph_end;
  logic [3:0]  ph_first;
  logic [3:0]  ph_next;

  assign ph_len = (ph_q < 4'(PHASES)) ? active_q.phase[8*ph_q +: 8] : 8'h00;
  assign ph_lim = {ph_len, 2'b00};
  assign eq_lim = {4'h0, active_q.eq_time, 2'b00};
  assign ph_end = (ph_q == 4'(PHASES)) ? eq_lim : ph_lim;

  // Zero-length phases are skipped and take no cycles, except the line's first phase after reset or a settings switch, which takes one cycle
  always_comb begin
    ph_first = (eq_lim == 10'h000) ? 4'(PHASES + 1) : 4'(PHASES);
    ph_next  = ph_first;
    for (int k = PHASES - 1; k >= 0; k--) begin
      if (active_q.phase[8*k +: 8] != 8'h00) begin
        ph_first = 4'(k);
        if (4'(k) > ph_q) begin
          ph_next = 4'(k);
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ph_q     <= 4'h0;
      ph_cnt_q <= 10'h000;
    end else if (line_wrap) begin
      ph_q     <= ph_first;
      ph_cnt_q <= 10'h000;
    end else if (ph_q <= 4'(PHASES)) begin
      if (ph_cnt_q + 10'h001 >= ph_end) begin
        ph_q     <= (ph_q == 4'(PHASES)) ? 4'(PHASES + 1) : ph_next;
        ph_cnt_q <= 10'h000;
      end else begin
        ph_cnt_q <= ph_cnt_q + 10'h001;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      phase_index_out             <= 4'h0;
      timing_generator_output_out <= 1'b0;
      equalize_out                <= 1'b0;
    end else begin
      phase_index_out             <= ph_q;
      timing_generator_output_out <= (ph_q < 4'(PHASES)) && ph_q[0];
      equalize_out                <= (ph_q == 4'(PHASES)) && (ph_cnt_q < eq_lim);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  a_cmd_opens: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (take_cmd && data_in == CMD_CODE) |=> (rx_q == CMGT_PARAM && idx_q == 5'h00))
    else $error("command code did not open intake");
  a_intake_ends: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (take_par && idx_q == PARAM_LAST && !take_cmd) |=> rx_q == CMGT_IDLE)
    else $error("intake did not close after twenty parameters");
  a_inv_field: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (take_par && idx_q == P_INV) |=> shadow_q.inv_idle == $past(data_in[5:3]))
    else $error("partial idle inversion field misplaced");
  a_inv_pick: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    partial_idle_in |=> inversion_select_out == $past(active_q.inv_idle[1:0]))
    else $error("wrong inversion selector in partial idle");
  a_frame_apply: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !$past(frame_wrap) |-> $stable(active_q))
    else $error("active timing changed outside frame boundary");
  a_line_len: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    line_wrap |-> line_pos_q == 12'(600 + 4 * line_length_setting_in - 1))
    else $error("line length wrong");
  a_sp_rise: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(gate_start_pulse_out) |-> $past(line_pos_q, 2) == {2'b00, active_q.sp_rise, 2'b00})
    else $error("start pulse rose at wrong point");
  a_sp_fall: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $fell(gate_start_pulse_out) |-> $past(line_pos_q, 2) == {2'b00, active_q.sp_end, 2'b00})
    else $error("start pulse ended at wrong point");
  a_ck_rise: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(gate_shift_pulse_out) |-> $past(line_pos_q, 2) == {2'b00, active_q.ck_rise, 2'b00})
    else $error("shift pulse rose at wrong point");
  a_eq_width: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    equalize_out |-> active_q.eq_time != 4'h0)
    else $error("equalize without period");

  c_cmd_seen: cover property (@(posedge sys_clk_in) take_cmd && data_in == CMD_CODE);
  c_all_params: cover property (@(posedge sys_clk_in) take_par && idx_q == PARAM_LAST);
  c_sp_pulse: cover property (@(posedge sys_clk_in) $fell(gate_start_pulse_out));
  c_ck_pulse: cover property (@(posedge sys_clk_in) $rose(gate_shift_pulse_out));

endmodule

// ### tb/cmgt_host_model.sv
`timescale 1ns/1ns
module cmgt_host_model
  import cmgt_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic [7:0] line_length_setting_in,
  output logic            write_strobe_out,
  output logic            data_command_select_out,
  output logic [7:0]      data_out
);
  initial begin
    write_strobe_out = 1'b0;
    data_command_select_out = 1'b0;
    data_out = 8'h00;
  end

  // One byte per edge; consecutive calls keep the strobe high
  task automatic send(input logic dcs, input logic [7:0] b);
    @(posedge sys_clk_in);
    write_strobe_out <= 1'b1;
    data_command_select_out <= dcs;
    data_out <= b;
  endtask

  // Released bus shows the inverse so a stale byte cannot pass
  task automatic idle();
    @(posedge sys_clk_in);
    write_strobe_out <= 1'b0;
    data_command_select_out <= 1'b0;
    data_out <= ~data_out;
  endtask

  // Sets that break the ordering limits are never sent
  task automatic send_timing(input logic [7:0] p [20]);
    if (p[3] < p[4] && p[4] <= line_length_setting_in &&
        p[6] < p[7] && p[7] <= line_length_setting_in) begin
      send(1'b0, CMD_CODE);
      for (int i = 0; i < PARAM_COUNT; i++) begin
        send(1'b1, p[i]);
      end
      idle();
    end
  endtask
endmodule

// ### tb/command_mode_gate_timing_config_tb.sv
`timescale 1ns/1ns
module command_mode_gate_timing_config_tb
  import cmgt_pkg::*;
;
  logic        sys_clk_in;
  logic        rst_in;
  logic        strobe;
  logic        dcs;
  logic [7:0]  data;
  logic [7:0]  line_len;
  logic [10:0] frame_lines;
  logic        partial_idle;
  logic        frame_start_out;
  logic        line_start_out;
  logic [1:0]  inv_out;
  logic        illegal_out;
  logic        gate_start_pulse;
  logic        ck;
  logic [3:0]  ph;
  logic        tgen;
  logic        eq;
  int          fails;
  int          n_compared;
  int          cyc, lpos, lcnt, ls_t, lp, sp_t, sp_l, sp_pos, sp_w, sp_pos_a;
  int          ck_t, ck_pos, ck_w, ck_per, ck_first, ck_pos_a, ph_t, eq_t, eq_w;
  int          dur [16];
  logic        sp_p, ck_p, eq_p, ck_seen;
  logic [3:0]  ph_p;
  logic [15:0] ph_seen, ph_mask;
  logic [7:0]  cfg_a [20] = '{8'h0A, 8'h00, 8'h02, 8'h05, 8'h14, 8'h01, 8'h03, 8'h0A, 8'h10, 8'h01,
                              8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h03};
  logic [7:0]  cfg_b [20] = '{8'h28, 8'h00, 8'h03, 8'h09, 8'h14, 8'h01, 8'h05, 8'h0A, 8'h00, 8'h13,
                              8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0F};
  logic [7:0]  cfg_c [20];

  cmgt_host_model u_host (
    .sys_clk_in             (sys_clk_in),
    .line_length_setting_in (line_len),
    .write_strobe_out       (strobe),
    .data_command_select_out(dcs),
    .data_out               (data)
  );

  cmgt_timing_gen u_dut (
    .sys_clk_in                 (sys_clk_in),
    .rst_in                     (rst_in),
    .write_strobe_in            (strobe),
    .data_command_select_in     (dcs),
    .data_in                    (data),
    .line_length_setting_in     (line_len),
    .frame_lines_in             (frame_lines),
    .partial_idle_in            (partial_idle),
    .frame_start_out            (frame_start_out),
    .line_start_out             (line_start_out),
    .inversion_select_out       (inv_out),
    .inversion_illegal_out      (illegal_out),
    .gate_start_pulse_out       (gate_start_pulse),
    .gate_shift_pulse_out       (ck),
    .phase_index_out            (ph),
    .timing_generator_output_out(tgen),
    .equalize_out               (eq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_eq(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wait_frames(input int n);
    repeat (n) @(posedge sys_clk_in iff frame_start_out === 1'b1);
    @(negedge sys_clk_in);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Edge timestamps of the gate pulse, phase and equalize waveforms, relative to line and frame starts
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    lpos <= line_start_out ? 0 : lpos + 1;
    if (line_start_out) begin
      lp <= cyc - ls_t;
      ls_t <= cyc;
      lcnt <= lcnt + 1;
    end
    if (frame_start_out) begin
      lcnt <= 0;
      ck_seen <= 1'b0;
    end
    if (gate_start_pulse && !sp_p) begin
      sp_t <= cyc;
      sp_l <= lcnt;
      sp_pos <= lpos;
    end
    if (!gate_start_pulse && sp_p) begin
      sp_w <= cyc - sp_t;
    end
    if (ck && !ck_p) begin
      ck_per <= cyc - ck_t;
      ck_t <= cyc;
      ck_pos <= lpos;
      ck_seen <= 1'b1;
      if (!ck_seen) begin
        ck_first <= lcnt;
      end
    end
    if (!ck && ck_p) begin
      ck_w <= cyc - ck_t;
    end
    if (ph != ph_p) begin
      dur[ph_p] <= cyc - ph_t;
      ph_t <= cyc;
    end
    if (eq && !eq_p) begin
      eq_t <= cyc;
    end
    if (!eq && eq_p) begin
      eq_w <= cyc - eq_t;
    end
    if (!rst_in && ph == ph_p && ph < 4'h9) begin
      check_eq("odd_phase_output", {31'h0000_0000, ph[0]}, {31'h0000_0000, tgen});
    end
    sp_p <= gate_start_pulse;
    ck_p <= ck;
    eq_p <= eq;
    ph_p <= ph;
    ph_seen <= line_start_out ? 16'h0000 : (ph_seen | (16'h0001 << ph));
    if (line_start_out) begin
      ph_mask <= ph_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_cfg_a();
    u_host.send_timing(cfg_a);
    @(negedge sys_clk_in);
    check_eq("inv_before_frame", 0, inv_out);
    wait_frames(2);
    check_eq("inv_norm", 2, inv_out);
    check_eq("line_period", LINE_BASE_CYC + 4 * 8'h20, lp);
    check_eq("sp_line", 2, sp_l);
    check_eq("sp_width", LINE_BASE_CYC + 4 * 8'h20 + 4 * 15, sp_w);
    check_eq("ck_first_line", 1, ck_first);
    check_eq("ck_width", 4 * 7, ck_w);
    check_eq("ck_period", 2 * (LINE_BASE_CYC + 4 * 8'h20), ck_per);
    for (int k = 0; k < PHASES; k++) begin
      check_eq("phase_len", 4 * (k + 1), dur[k]);
    end
    check_eq("eq_phase", 4 * 3, dur[9]);
    check_eq("eq_width", 4 * 3, eq_w);
    sp_pos_a = sp_pos;
    ck_pos_a = ck_pos;
  endtask

  task automatic t_cfg_b();
    @(posedge sys_clk_in);
    line_len <= 8'hFF;
    partial_idle <= 1'b1;
    u_host.send_timing(cfg_b);
    wait_frames(2);
    check_eq("illegal_idle", 1, illegal_out);
    check_eq("inv_idle_low", 1, inv_out);
    check_eq("line_period_max", LINE_BASE_CYC + 4 * 8'hFF, lp);
    check_eq("sp_line_b", 3, sp_l);
    check_eq("sp_rise_shift", 4 * 4, sp_pos - sp_pos_a);
    check_eq("sp_width_b", 4 * 11, sp_w);
    check_eq("ck_rise_shift", 4 * 2, ck_pos - ck_pos_a);
    check_eq("ck_width_b", LINE_BASE_CYC + 4 * 8'hFF + 4 * 5, ck_w);
    check_eq("ck_period_b", 4 * (LINE_BASE_CYC + 4 * 8'hFF), ck_per);
    check_eq("phase_max", 4 * 8'hFF, dur[0]);
    for (int k = 1; k < PHASES; k++) begin
      check_eq("phase_skipped", 0, ph_mask[k]);
    end
    check_eq("eq_phase_seen", 1, ph_mask[PHASES]);
    check_eq("eq_width_max", 60, eq_w);
  endtask

  task automatic t_refused();
    cfg_c = cfg_a;
    cfg_c[0] = 8'h03;
    @(posedge sys_clk_in);
    partial_idle <= 1'b0;
    u_host.send_timing(cfg_c);
    u_host.send(1'b1, 8'h06);
    u_host.send(1'b0, 8'hB2);
    u_host.send(1'b1, 8'h06);
    u_host.idle();
    wait_frames(2);
    check_eq("inv_dot4", 3, inv_out);
    check_eq("illegal_norm", 0, illegal_out);
    @(posedge sys_clk_in);
    partial_idle <= 1'b1;
    wait_frames(1);
    check_eq("inv_idle_col", 0, inv_out);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  initial begin
    repeat (100000) @(posedge sys_clk_in);
    fails++;
    report_and_stop();
  end

  initial begin
    rst_in = 1'b1;
    line_len = 8'h20;
    frame_lines = 11'h006;
    partial_idle = 1'b0;
    repeat (10) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    check_eq("rst_outputs", 0, {frame_start_out, line_start_out, inv_out, illegal_out, gate_start_pulse, ck, ph, tgen, eq});
    @(posedge sys_clk_in);
    rst_in <= 1'b0;
    t_cfg_a();
    t_cfg_b();
    t_refused();
    report_and_stop();
  end
endmodule
